// ==== design/aux_ctrl_pkg.sv ====
package aux_ctrl_pkg;
    // Register byte offsets on the APB bus
    localparam logic [7:0] LEN_STBY_OFS = 8'h00;
    localparam logic [7:0] PLL_CTRL_OFS = 8'h04;
    localparam logic [7:0] CTRL_ZERO_OFS = 8'h08;
    localparam logic [7:0] TX_TARGET_OFS = 8'h0C;
    localparam logic [7:0] TX_COUNT_OFS = 8'h10;
    localparam logic [7:0] STATUS_OFS = 8'h14;
    localparam logic [7:0] BAUD_LOAD_OFS = 8'h18;
    localparam logic [7:0] CLK_SEL_OFS = 8'h1C;
    // Field positions
    localparam int LCE_BIT = 1;
    localparam int STBY_BIT = 0;
    localparam int CMD_LSB = 5;
    localparam int LOCAL_BIT = 4;
    localparam int ECHO_BIT = 3;
    localparam int BRG_SYS_BIT = 2;
    localparam int RX_GEN_BIT = 1;
    localparam int TX_GEN_BIT = 0;
    localparam int XTAL_SEL_BIT = 7;
    localparam int PLL_TX_SEL_BIT = 6;
    localparam int ABORT_BIT = 0;
    // Values
    localparam logic [7:0] STBY_EXIT_VAL = 8'h00;
    localparam logic [15:0] TARGET_RESET = 16'h0000;
    localparam logic [15:0] BAUD_RESET = 16'h0000;
    typedef enum logic [2:0] {
        CMD_NONE = 3'h0,
        CMD_SEARCH = 3'h1,
        CMD_CLR_MISS = 3'h2,
        CMD_DISABLE = 3'h3,
        CMD_SRC_BRG = 3'h4,
        CMD_SRC_PIN = 3'h5,
        CMD_FM = 3'h6,
        CMD_NRZI = 3'h7
    } pll_cmd_e;
    typedef enum logic [1:0] {
        SRC_SYNC_PIN = 2'h0,
        SRC_CRYSTAL = 2'h1,
        SRC_TX_GEN = 2'h3,
        SRC_RX_GEN = 2'h2
    } pll_src_e;
endpackage

// ==== design/serial_aux_control.sv ====
// Overview of operation
// - In bit-oriented mode with counter enabled, count each transmit request, compare with target.
// - At count equal to target, mask further transmit requests and hold the count.
// - Writing the counter enable bit to one clears the count.
// - On underrun with counting enabled and count matching, close frame with check and flag.
// - On mismatch at underrun, send abort, mask requests, hold count, set abort status.
// - The request mask lifts only when counting is enabled again, clearing the count.
// - Standby bit one enters standby, zero does nothing; writing 00 to register zero exits.
// - The standby bit clears itself when standby ends.
// - In standby only the system clock runs; serial data holds; clock pins float.
// - Loop command reset state: loop off, sync pin source, NRZI decoding.
// - Command 001 starts edge search and sampling; command 000 does nothing.
// - Command 010 clears both missing-clock bits, only while FM is selected.
// - Command 011 stops the loop and clears both missing-clock bits.
// - Command 100 takes a baud generator source, 101 the crystal or sync pin.
// - Command 110 selects FM decoding, 111 selects NRZI decoding.
// - Local self-test loops transmitter to receiver, ignores input pin, CTS and DCD.
// - Echo loop ties serial input to output, disables transmitter and CTS control.
// - Baud source bit picks crystal or sync pin at 0, system clock at 1.
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
module serial_aux_control #(
    parameter int COUNT_W = 16
) (
    input wire logic clock_in, // 40 MHz system clock
    input wire logic reset_n_in, // Synchronous reset, active low
    input wire logic psel_in, // APB select
    input wire logic penable_in, // APB enable
    input wire logic pwrite_in, // APB direction
    input wire logic [7:0] paddr_in, // APB byte address
    input wire logic [31:0] pwdata_in, // APB write data
    output logic [31:0] prdata_out, // APB read data
    output logic pready_out, // APB ready
    output logic pslverr_out, // APB error, unmapped address
    input wire logic bop_mode_in, // Bit-oriented mode selected
    input wire logic tx_req_in, // Raw transmit service request pulse
    input wire logic underrun_in, // Underrun or end-of-message pulse
    input wire logic tx_data_in, // Transmitter serial output
    input wire logic [1:0] missing_clock_in, // Loop missing-clock events
    input wire logic serial_pin_in, // Serial data pin
    input wire logic cts_n_in, // Clear-to-send pin
    input wire logic dcd_n_in, // Carrier-detect pin
    input wire logic crystal_sync_pin_in, // Crystal or sync pin level
    input wire logic sync_rx_clock_pin_in, // Sync receive clock pin level
    input wire logic clock_pin_drive_in, // Clock pin wants to drive
    input wire logic crystal_sync_drive_in, // Crystal/sync pin wants to drive
    output logic tx_service_request_out, // Masked transmit request pulse
    output logic close_frame_out, // Send check sequence and flag
    output logic send_abort_out, // Send abort pulse
    output logic serial_out, // Serial data pin
    output logic rx_data_out, // Data to receiver
    output logic cts_ok_out, // Transmit permitted by CTS
    output logic dcd_ok_out, // Receive permitted by DCD
    output logic tx_enable_out, // Transmitter function enabled
    output logic standby_out, // Standby mode active
    output logic clock_pin_oe_out, // Clock pin output enable
    output logic crystal_sync_oe_out, // Crystal/sync pin output enable
    output logic pll_enable_out, // Loop running
    output logic pll_search_out, // Loop searching for edges
    output logic pll_fm_out, // FM decoding selected, else NRZI
    output logic [1:0] pll_source_out, // Loop clock source
    output logic tx_baud_tick_out, // Transmit generator reached zero
    output logic rx_baud_tick_out // Receive generator reached zero
);
    typedef struct packed {
        logic [4:0] sync1;
        logic [4:0] sync2;
        logic [1:0] prev_clk;
        logic lce;
        logic standby;
        logic masked;
        logic abort_flag;
        logic [COUNT_W-1:0] target;
        logic [COUNT_W-1:0] count;
        logic pll_en;
        logic search;
        logic fm;
        logic [1:0] src;
        logic [1:0] missing;
        logic local_test;
        logic echo;
        logic brg_sys;
        logic rx_gen_en;
        logic tx_gen_en;
        logic xtal_sel;
        logic pll_tx_sel;
        logic [15:0] tx_load;
        logic [15:0] rx_load;
        logic [15:0] tx_cnt;
        logic [15:0] rx_cnt;
        logic tx_tick;
        logic rx_tick;
        logic tx_req;
        logic close_frame;
        logic send_abort;
        logic serial;
        logic rx_data;
        logic cts_ok;
        logic dcd_ok;
        logic tx_en;
        logic clk_oe;
        logic xs_oe;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } state_s;

    state_s st;
    state_s next_st;
    logic access;
    logic wr;
    logic src_edge;
    logic [2:0] cmd;
    logic mapped;
    logic [31:0] rdata;

    always_comb begin
        next_st = st;
        access = psel_in && penable_in && st.pready;
        wr = access && pwrite_in;
        cmd = pwdata_in[aux_ctrl_pkg::CMD_LSB +: 3];
        mapped = 1'b1;
        rdata = 32'h0000_0000;
        next_st.sync1 = {serial_pin_in, cts_n_in, dcd_n_in, crystal_sync_pin_in, sync_rx_clock_pin_in};
        next_st.sync2 = st.sync1;
        next_st.prev_clk = st.sync2[1:0];
        next_st.tx_req = 1'b0;
        next_st.close_frame = 1'b0;
        next_st.send_abort = 1'b0;
        next_st.tx_tick = 1'b0;
        next_st.rx_tick = 1'b0;

        // Transmit length counting
        if (tx_req_in && !st.masked) begin
            next_st.tx_req = 1'b1;
            if (st.lce && bop_mode_in) begin
                next_st.count = st.count + 1'b1;
                if (st.count + 1'b1 == st.target) begin
                    next_st.masked = 1'b1;
                end
            end
        end
        if (underrun_in && st.lce && bop_mode_in) begin
            if (st.count == st.target) begin
                next_st.close_frame = 1'b1;
            end else begin
                next_st.send_abort = 1'b1;
                next_st.masked = 1'b1;
                next_st.count = st.count;
                next_st.abort_flag = 1'b1;
            end
        end

        // Missing-clock events only matter while FM decoding runs
        next_st.missing = st.missing | (missing_clock_in & {2{st.pll_en && st.fm}});

        // Register file
        unique case (paddr_in)
            aux_ctrl_pkg::LEN_STBY_OFS: rdata = {30'h0000_0000, st.lce, st.standby};
            aux_ctrl_pkg::PLL_CTRL_OFS: begin
                rdata = {27'h0000_0000, st.local_test, st.echo, st.brg_sys, st.rx_gen_en, st.tx_gen_en};
            end
            aux_ctrl_pkg::CTRL_ZERO_OFS: rdata = 32'h0000_0000;
            aux_ctrl_pkg::TX_TARGET_OFS: rdata = 32'(st.target);
            aux_ctrl_pkg::TX_COUNT_OFS: rdata = 32'(st.count);
            aux_ctrl_pkg::STATUS_OFS: begin
                rdata = {22'h00_0000, st.missing, 1'b0, st.src, st.fm, st.search, st.pll_en, st.masked,
                         st.abort_flag};
            end
            aux_ctrl_pkg::BAUD_LOAD_OFS: rdata = {st.rx_load, st.tx_load};
            aux_ctrl_pkg::CLK_SEL_OFS: rdata = {24'h00_0000, st.xtal_sel, st.pll_tx_sel, 6'h00};
            default: mapped = 1'b0;
        endcase

        if (wr && mapped) begin
            case (paddr_in)
                aux_ctrl_pkg::LEN_STBY_OFS: begin
                    next_st.lce = pwdata_in[aux_ctrl_pkg::LCE_BIT];
                    if (pwdata_in[aux_ctrl_pkg::LCE_BIT]) begin
                        next_st.count = '0;
                        next_st.masked = 1'b0;
                    end
                    if (pwdata_in[aux_ctrl_pkg::STBY_BIT]) begin
                        next_st.standby = 1'b1;
                    end
                end
                aux_ctrl_pkg::PLL_CTRL_OFS: begin
                    next_st.local_test = pwdata_in[aux_ctrl_pkg::LOCAL_BIT];
                    next_st.echo = pwdata_in[aux_ctrl_pkg::ECHO_BIT];
                    next_st.brg_sys = pwdata_in[aux_ctrl_pkg::BRG_SYS_BIT];
                    next_st.rx_gen_en = pwdata_in[aux_ctrl_pkg::RX_GEN_BIT];
                    next_st.tx_gen_en = pwdata_in[aux_ctrl_pkg::TX_GEN_BIT];
                    case (cmd)
                        aux_ctrl_pkg::CMD_SEARCH: begin
                            next_st.pll_en = 1'b1;
                            next_st.search = 1'b1;
                        end
                        aux_ctrl_pkg::CMD_CLR_MISS: begin
                            if (st.fm) begin
                                next_st.missing = missing_clock_in & {2{st.pll_en}};
                            end
                        end
                        aux_ctrl_pkg::CMD_DISABLE: begin
                            next_st.pll_en = 1'b0;
                            next_st.search = 1'b0;
                            next_st.missing = 2'b00;
                        end
                        aux_ctrl_pkg::CMD_SRC_BRG: begin
                            next_st.src = st.pll_tx_sel ? aux_ctrl_pkg::SRC_TX_GEN : aux_ctrl_pkg::SRC_RX_GEN;
                        end
                        aux_ctrl_pkg::CMD_SRC_PIN: begin
                            next_st.src = st.xtal_sel ? aux_ctrl_pkg::SRC_CRYSTAL : aux_ctrl_pkg::SRC_SYNC_PIN;
                        end
                        aux_ctrl_pkg::CMD_FM: next_st.fm = 1'b1;
                        aux_ctrl_pkg::CMD_NRZI: next_st.fm = 1'b0;
                        default: next_st.fm = st.fm;
                    endcase
                end
                aux_ctrl_pkg::CTRL_ZERO_OFS: begin
                    if (pwdata_in[7:0] == aux_ctrl_pkg::STBY_EXIT_VAL) begin
                        next_st.standby = 1'b0;
                    end
                end
                aux_ctrl_pkg::TX_TARGET_OFS: next_st.target = pwdata_in[COUNT_W-1:0];
                aux_ctrl_pkg::STATUS_OFS: begin
                    // Set wins over the clear
                    if (pwdata_in[aux_ctrl_pkg::ABORT_BIT] && !next_st.send_abort) begin
                        next_st.abort_flag = 1'b0;
                    end
                end
                aux_ctrl_pkg::BAUD_LOAD_OFS: begin
                    next_st.tx_load = pwdata_in[15:0];
                    next_st.rx_load = pwdata_in[31:16];
                end
                aux_ctrl_pkg::CLK_SEL_OFS: begin
                    next_st.xtal_sel = pwdata_in[aux_ctrl_pkg::XTAL_SEL_BIT];
                    next_st.pll_tx_sel = pwdata_in[aux_ctrl_pkg::PLL_TX_SEL_BIT];
                end
                default: next_st.lce = st.lce;
            endcase
        end

        // One wait state per transfer
        next_st.pready = psel_in && penable_in && !st.pready;
        next_st.pslverr = psel_in && penable_in && !st.pready && !mapped;
        if (psel_in && penable_in && !st.pready && !pwrite_in) begin
            next_st.prdata = rdata;
        end

        // Baud generators; all source edges, system clock included, are ignored in standby
        src_edge = st.brg_sys ||
                   (st.xtal_sel ? (st.sync2[1] && !st.prev_clk[1]) : (st.sync2[0] && !st.prev_clk[0]));
        src_edge = src_edge && !st.standby;
        if (!st.tx_gen_en) begin
            next_st.tx_cnt = st.tx_load;
        end else if (src_edge) begin
            next_st.tx_cnt = (st.tx_cnt == 16'h0000) ? st.tx_load : st.tx_cnt - 16'h0001;
            next_st.tx_tick = (st.tx_cnt == 16'h0000);
        end
        if (!st.rx_gen_en) begin
            next_st.rx_cnt = st.rx_load;
        end else if (src_edge) begin
            next_st.rx_cnt = (st.rx_cnt == 16'h0000) ? st.rx_load : st.rx_cnt - 16'h0001;
            next_st.rx_tick = (st.rx_cnt == 16'h0000);
        end

        // Line test paths
        next_st.rx_data = st.local_test ? tx_data_in : st.sync2[4];
        next_st.cts_ok = st.local_test || st.echo || !st.sync2[3];
        next_st.dcd_ok = st.local_test || !st.sync2[2];
        next_st.tx_en = !st.echo;
        if (!st.standby) begin
            next_st.serial = st.echo ? st.sync2[4] : tx_data_in;
        end
        // Clock pins float in standby; serial output holds
        next_st.clk_oe = clock_pin_drive_in && !st.standby;
        next_st.xs_oe = crystal_sync_drive_in && !st.standby;
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            st <= '0;
            st.target <= aux_ctrl_pkg::TARGET_RESET[COUNT_W-1:0];
            st.tx_load <= aux_ctrl_pkg::BAUD_RESET;
            st.rx_load <= aux_ctrl_pkg::BAUD_RESET;
            st.src <= aux_ctrl_pkg::SRC_SYNC_PIN;
            st.serial <= 1'b1;
            st.tx_en <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign prdata_out = st.prdata;
    assign pready_out = st.pready;
    assign pslverr_out = st.pslverr;
    assign tx_service_request_out = st.tx_req;
    assign close_frame_out = st.close_frame;
    assign send_abort_out = st.send_abort;
    assign serial_out = st.serial;
    assign rx_data_out = st.rx_data;
    assign cts_ok_out = st.cts_ok;
    assign dcd_ok_out = st.dcd_ok;
    assign tx_enable_out = st.tx_en;
    assign standby_out = st.standby;
    assign clock_pin_oe_out = st.clk_oe;
    assign crystal_sync_oe_out = st.xs_oe;
    assign pll_enable_out = st.pll_en;
    assign pll_search_out = st.search;
    assign pll_fm_out = st.fm;
    assign pll_source_out = st.src;
    assign tx_baud_tick_out = st.tx_tick;
    assign rx_baud_tick_out = st.rx_tick;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);

    logic wr_q;
    logic [7:0] addr_q;
    logic [31:0] data_q;
    always_ff @(posedge clock_in) begin
        wr_q <= psel_in && penable_in && pwrite_in && st.pready;
        addr_q <= paddr_in;
        data_q <= pwdata_in;
    end

    count_step_a: assert property (tx_req_in && !st.masked && st.lce && bop_mode_in && !underrun_in
        && !(psel_in && penable_in && st.pready && pwrite_in) |=> st.count == $past(st.count) + 1'b1)
        else $error("length count did not step");
    mask_hold_a: assert property (st.masked && !(psel_in && penable_in && pwrite_in)
        |=> !st.tx_req && st.count == $past(st.count))
        else $error("masked request passed or count moved");
    lce_clear_a: assert property (wr_q && addr_q == aux_ctrl_pkg::LEN_STBY_OFS && data_q[aux_ctrl_pkg::LCE_BIT]
        |-> st.count == '0 && !st.masked)
        else $error("enable write did not clear count");
    close_frame_a: assert property (underrun_in && st.lce && bop_mode_in && st.count == st.target
        |=> close_frame_out && !send_abort_out)
        else $error("matching underrun did not close frame");
    abort_a: assert property (underrun_in && st.lce && bop_mode_in && st.count != st.target
        |=> send_abort_out && st.masked && st.abort_flag)
        else $error("mismatch did not abort");
    stby_exit_a: assert property (st.standby && !(wr && paddr_in == aux_ctrl_pkg::CTRL_ZERO_OFS
        && pwdata_in[7:0] == aux_ctrl_pkg::STBY_EXIT_VAL) |=> st.standby)
        else $error("standby left without exit write");
    stby_float_a: assert property (st.standby |=> !clock_pin_oe_out && !crystal_sync_oe_out
        && serial_out == $past(serial_out))
        else $error("pins not released in standby");
    stby_zero_a: assert property (wr_q && addr_q == aux_ctrl_pkg::CTRL_ZERO_OFS && data_q[7:0] == 8'h00
        |-> !st.standby)
        else $error("standby did not end");
    pll_off_a: assert property (wr_q && addr_q == aux_ctrl_pkg::PLL_CTRL_OFS && data_q[7:5] == 3'h3
        |-> !st.pll_en && st.missing == 2'b00)
        else $error("loop disable failed");
    local_loop_a: assert property (st.local_test |=> rx_data_out == $past(tx_data_in) && dcd_ok_out)
        else $error("local loop path wrong");
    echo_a: assert property (st.echo && !st.standby |=> !tx_enable_out && serial_out == $past(st.sync2[4]))
        else $error("echo path wrong");
    gen_halt_a: assert property (!st.tx_gen_en |=> st.tx_cnt == $past(st.tx_load) && !tx_baud_tick_out)
        else $error("halted generator moved");

    abort_c: cover property (send_abort_out);
    close_c: cover property (close_frame_out);
    stby_c: cover property (st.standby ##[1:20] !st.standby);
    tick_c: cover property (tx_baud_tick_out && st.brg_sys);
endmodule

// ==== dv/aux_line_model.sv ====
`timescale 1ns/1ps
module aux_line_model (
    input wire logic clock_in, // System clock
    input wire logic standby_in, // Device sits in standby
    output logic serial_pin_out, // Line data toward the device
    output logic cts_n_out, // Clear-to-send, low active
    output logic dcd_n_out // Carrier detect, low active
);
    logic [7:0] lfsr = 8'h5a;
    // Remote end never grants, so only the test modes can show permission
    assign cts_n_out = 1'b1;
    assign dcd_n_out = 1'b1;
    assign serial_pin_out = lfsr[0];
    // Line pattern freezes while the device sleeps
    always @(posedge clock_in) begin
        if (!standby_in) begin
            lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        end
    end
endmodule

// ==== dv/serial_aux_control_tb.sv ====
`timescale 1ns/1ps
module serial_aux_control_tb;
    localparam logic [32:0] ALL = 33'h1_ffff_ffff;
    localparam logic [32:0] MISS = 33'h0_0000_0300;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, bop = 1'b0, txr = 1'b0, und = 1'b0, txd = 1'b0, v;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [1:0] miss = 2'h0;
    logic srx = 1'b0;
    logic [31:0] prdata;
    logic [1:0] psrc;
    logic pready, pslverr, pin, cts_n, dcd_n, tsr, cfr, sab, sout, rxd, ctok, dcdok, txen, stby;
    logic cpoe, xsoe, pen, psrch, pfm, ttick, rtick;
    typedef struct {logic [32:0] e; logic [32:0] m;} note_s;
    note_s notes[$];
    int n_errors = 0, total_checks = 0, n_req = 0, n_close = 0, n_abort = 0, n_tt = 0, n_rt = 0, cyc = 0;
    integer seed = 32403;

    always #12.5 clk = ~clk;

    aux_line_model line (.clock_in(clk), .standby_in(stby), .serial_pin_out(pin), .cts_n_out(cts_n),
        .dcd_n_out(dcd_n));

    serial_aux_control DUT (.clock_in(clk), .reset_n_in(rst_n), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .bop_mode_in(bop), .tx_req_in(txr), .underrun_in(und), .tx_data_in(txd),
        .missing_clock_in(miss), .serial_pin_in(pin), .cts_n_in(cts_n), .dcd_n_in(dcd_n),
        .crystal_sync_pin_in(1'b0), .sync_rx_clock_pin_in(srx), .clock_pin_drive_in(1'b1),
        .crystal_sync_drive_in(1'b1), .tx_service_request_out(tsr), .close_frame_out(cfr),
        .send_abort_out(sab), .serial_out(sout), .rx_data_out(rxd), .cts_ok_out(ctok), .dcd_ok_out(dcdok),
        .tx_enable_out(txen), .standby_out(stby), .clock_pin_oe_out(cpoe), .crystal_sync_oe_out(xsoe),
        .pll_enable_out(pen), .pll_search_out(psrch), .pll_fm_out(pfm), .pll_source_out(psrc),
        .tx_baud_tick_out(ttick), .rx_baud_tick_out(rtick));

    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [32:0] e, input logic [32:0] s);
        total_checks++;
        if (s !== e) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
        notes.push_back('{e, m});
        apb(1'b0, a, 32'h0000_0000);
    endtask

    task automatic cmd(input logic [2:0] c);
        wr(aux_ctrl_pkg::PLL_CTRL_OFS, {24'h00_0000, c, 5'h00});
    endtask

    // Kind 0 transmit request, 1 underrun, 2 and 3 missing-clock bit 0 and 1
    task automatic pulse(input int k, input int n);
        txr <= (k == 0);
        und <= (k == 1);
        miss <= {k == 3, k == 2};
        repeat (n) @(posedge clk);
        txr <= 1'b0;
        und <= 1'b0;
        miss <= 2'b00;
        repeat (3) @(posedge clk);
    endtask

    // Oldest read note is taken off whenever a read completes
    always @(posedge clk) begin
        note_s nt;
        cyc++;
        n_req += tsr;
        n_close += cfr;
        n_abort += sab;
        n_tt += ttick;
        n_rt += rtick;
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            nt = notes.pop_front();
            chk("read", nt.e, {pslverr, prdata} & nt.m);
        end
        if (cyc == 20000) begin
            n_errors++;
            final_report();
        end
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk("pll_state", 0, {pen, pfm, psrc});
        chk("cts_ok", 0, ctok);
        bop <= 1'b1;
        wr(aux_ctrl_pkg::TX_TARGET_OFS, 32'h0000_0003);
        wr(aux_ctrl_pkg::LEN_STBY_OFS, 32'h0000_0002);
        pulse(0, 4);
        chk("requests", 3, n_req);
        rd(aux_ctrl_pkg::TX_COUNT_OFS, 33'h0_0000_0003, ALL);
        pulse(1, 1);
        chk("close", 1, n_close);
        wr(aux_ctrl_pkg::LEN_STBY_OFS, 32'h0000_0000);
        wr(aux_ctrl_pkg::LEN_STBY_OFS, 32'h0000_0002);
        rd(aux_ctrl_pkg::TX_COUNT_OFS, 33'h0_0000_0000, ALL);
        wr(aux_ctrl_pkg::TX_TARGET_OFS, 32'h0000_0005);
        pulse(0, 2);
        pulse(1, 1);
        chk("abort", 1, n_abort);
        rd(aux_ctrl_pkg::STATUS_OFS, 33'h0_0000_0003, 33'h0_0000_0003);
        pulse(0, 1);
        chk("requests", 5, n_req);
        wr(aux_ctrl_pkg::LEN_STBY_OFS, 32'h0000_0002);
        pulse(0, 1);
        chk("requests", 6, n_req);
        wr(aux_ctrl_pkg::LEN_STBY_OFS, 32'h0000_0003);
        chk("standby", 1, stby);
        chk("clock_pin_oe", 0, cpoe);
        chk("xs_oe", 0, xsoe);
        wr(aux_ctrl_pkg::LEN_STBY_OFS, 32'h0000_0002);
        chk("standby", 1, stby);
        wr(aux_ctrl_pkg::CTRL_ZERO_OFS, {24'h00_0000, aux_ctrl_pkg::STBY_EXIT_VAL});
        chk("standby", 0, stby);
        rd(aux_ctrl_pkg::LEN_STBY_OFS, 33'h0_0000_0002, ALL);
        chk("clock_pin_oe", 1, cpoe);
        chk("xs_oe", 1, xsoe);
        wr(aux_ctrl_pkg::CLK_SEL_OFS, 32'h0000_0040);
        cmd(3'h1);
        chk("search", 1, psrch);
        cmd(3'h0);
        chk("search", 1, psrch);
        cmd(3'h6);
        chk("fm", 1, pfm);
        pulse(2, 1);
        rd(aux_ctrl_pkg::STATUS_OFS, 33'h0_0000_0100, MISS);
        cmd(3'h2);
        rd(aux_ctrl_pkg::STATUS_OFS, 33'h0_0000_0000, MISS);
        // Events are only latched while FM runs, so raise one before leaving FM
        pulse(3, 1);
        cmd(3'h7);
        chk("fm", 0, pfm);
        cmd(3'h2);
        rd(aux_ctrl_pkg::STATUS_OFS, 33'h0_0000_0200, MISS);
        cmd(3'h3);
        chk("enable", 0, pen);
        rd(aux_ctrl_pkg::STATUS_OFS, 33'h0_0000_0000, MISS);
        cmd(3'h4);
        chk("source", 3, psrc);
        wr(aux_ctrl_pkg::CLK_SEL_OFS, 32'h0000_0080);
        cmd(3'h5);
        chk("source", 1, psrc);
        wr(aux_ctrl_pkg::PLL_CTRL_OFS, 32'h0000_0010);
        chk("cts_ok", 1, ctok);
        chk("dcd_ok", 1, dcdok);
        repeat (8) begin
            v = $random(seed);
            txd <= v;
            repeat (2) @(posedge clk);
            chk("rx_data", v, rxd);
            chk("serial", v, sout);
        end
        wr(aux_ctrl_pkg::PLL_CTRL_OFS, 32'h0000_0008);
        chk("tx_enable", 0, txen);
        chk("cts_ok", 1, ctok);
        wr(aux_ctrl_pkg::BAUD_LOAD_OFS, 32'h0003_0003);
        wr(aux_ctrl_pkg::PLL_CTRL_OFS, 32'h0000_0005);
        n_tt = 0;
        n_rt = 0;
        repeat (40) @(posedge clk);
        chk("tx_ticks", 1, n_tt >= 9 && n_tt <= 11);
        chk("rx_ticks", 0, n_rt);
        wr(aux_ctrl_pkg::PLL_CTRL_OFS, 32'h0000_0004);
        n_tt = 0;
        repeat (40) @(posedge clk);
        chk("tx_ticks", 0, n_tt);
        wr(aux_ctrl_pkg::CLK_SEL_OFS, 32'h0000_0000);
        wr(aux_ctrl_pkg::PLL_CTRL_OFS, 32'h0000_0001);
        n_tt = 0;
        // Eight rising edges on the sync clock pin, reload 3 gives a tick every fourth
        repeat (16) begin
            srx <= ~srx;
            repeat (2) @(posedge clk);
        end
        repeat (4) @(posedge clk);
        chk("tx_ticks", 2, n_tt);
        rd(8'h20, 33'h1_0000_0000, ALL);
        final_report();
    end
endmodule
